//--- include/tshi_defines.vh
/*
  Constants for the touch sensor host interface: timing figures,
  register byte addresses, control bit positions and frame sizes.
  Assumes a 200 MHz core clock; included by bare name.
*/
`ifndef TSHI_DEFINES_VH
`define TSHI_DEFINES_VH

// ****************************
// timing
// ****************************
`define TSHI_CLK_MHZ 200
`define TSHI_INIT_US 1
`define TSHI_INIT_CYC (`TSHI_INIT_US * `TSHI_CLK_MHZ)
`define TSHI_SPI_RDY_MS 50
`define TSHI_SPI_RDY_CYC (`TSHI_SPI_RDY_MS * 1000 * `TSHI_CLK_MHZ)
`define TSHI_FULL_MS 400
`define TSHI_FULL_CYC (`TSHI_FULL_MS * 1000 * `TSHI_CLK_MHZ)
`define TSHI_TMO_MS 10
`define TSHI_TMO_CYC (`TSHI_TMO_MS * 1000 * `TSHI_CLK_MHZ)
`define TSHI_GAP_US 500
`define TSHI_GAP_CYC (`TSHI_GAP_US * `TSHI_CLK_MHZ)
`define TSHI_GRACE_US 20
`define TSHI_GRACE_CYC (`TSHI_GRACE_US * `TSHI_CLK_MHZ)
`define TSHI_BURST_US 1000
`define TSHI_BURST_CYC (`TSHI_BURST_US * `TSHI_CLK_MHZ)
`define TSHI_LP_GAP_MS 100
`define TSHI_LP_GAP_CYC (`TSHI_LP_GAP_MS * 1000 * `TSHI_CLK_MHZ)
`define TSHI_CAL_BURSTS 4'hF

// ****************************
// frame
// ****************************
`define TSHI_LAST_BIT 5'h17
`define TSHI_FRAME_W 24

// ****************************
// registers
// ****************************
`define TSHI_A_CTRL 8'h00
`define TSHI_A_TX 8'h04
`define TSHI_A_KEYOK 8'h08
`define TSHI_A_RXCFG 8'h0C
`define TSHI_A_STAT 8'h10
`define TSHI_C_LP 0
`define TSHI_C_SUPP 1
`define TSHI_C_RECAL 2
`define TSHI_C_APPLY 3

`endif

//--- logic/tshi_top.v
/*
  Host-facing side of a capacitive touch controller: start-up
  sequencing, spread strap capture, three-byte SPI slave with frame
  timeout, change flag and acquisition-idle flag with burst timing.
  Assumes SPI pins and the strap come from outside the clk domain;
  the register port is driven synchronously to clk.
*/
// How it works
// RQ1 - strap high selects spread burst frequency, low selects fixed frequency
// RQ2 - during reset every output enable is low
// RQ3 - after the first reset phase idle flag drives low, change flag high
// RQ4 - serial interface ignored until 50 ms after reset release
// RQ5 - change flag stays high after reset until a frame is read
// RQ6 - calibration takes 15 bursts; no touches reported before it ends
// RQ7 - fully functional 400 ms after reset release
// RQ8 - out-of-range keys masked; recalibration re-examines them
// RQ9 - reset leaves continuous mode with touch suppression off
// RQ10 - slave only, on select, clock, data in and data out
// RQ11 - frame not done within 10 ms is dropped; next bit starts anew
// RQ12 - received bytes are configuration, sent bytes are key state
// RQ13 - host waits after select falls before the first clock edge
// RQ14 - data in sampled on clock rise, data out changed on clock fall
// RQ15 - select may rise between bytes without breaking the frame
// RQ16 - select held low keeps the block out of deepest sleep
// RQ17 - changed key data raises the change flag
// RQ18 - an applied new setting raises the change flag
// RQ19 - only a completed frame lowers the change flag
// RQ20 - idle flag low in bursts, high 500 us between and while asleep
// RQ21 - after a complete frame idle flag low until next burst ends
// RQ22 - select within 20 us of burst start holds flag high, no burst
// RQ23 - each frame shifts three bytes each way at once
// RQ24 - host may use the idle flag to avoid bursts
// RQ25 - data out undriven while select is high
`timescale 1ns/1ps
`default_nettype none
`include "tshi_defines.vh"

module tshi_top #(
  parameter [27:0] SPI_RDY_CYC = `TSHI_SPI_RDY_CYC,
  parameter [27:0] FULL_CYC = `TSHI_FULL_CYC,
  parameter [27:0] TMO_CYC = `TSHI_TMO_CYC,
  parameter [27:0] GAP_CYC = `TSHI_GAP_CYC,
  parameter [27:0] BURST_CYC = `TSHI_BURST_CYC,
  parameter [27:0] LP_GAP_CYC = `TSHI_LP_GAP_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire spread_strap,
  input wire spi_ss_n,
  input wire spi_sck,
  input wire spi_mosi,
  output reg spi_miso_o,
  output reg spi_miso_oe,
  output reg change_flag_o,
  output reg change_flag_oe,
  output reg acquisition_idle_flag_o,
  output reg acquisition_idle_flag_oe,
  output reg spread_en_o,
  output reg sleep_ok_o,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);

  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_BURST = 2'h1;
  localparam [1:0] ST_GAP = 2'h2;
  localparam [1:0] ST_HOLD = 2'h3;
  localparam [27:0] INIT_CYC = `TSHI_INIT_CYC;
  localparam [27:0] GRACE_CYC = `TSHI_GRACE_CYC;

  // ****************************
  // pin synchronisers
  // ****************************
  reg ss_m_r, ss_s_r, ss_d_r;
  reg sck_m_r, sck_s_r, sck_d_r;
  reg mosi_m_r, mosi_s_r;
  reg strap_m_r, strap_s_r;

  // two flops per pin, a third only for edge finding
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_m_r <= 1'b1;
      ss_s_r <= 1'b1;
      ss_d_r <= 1'b1;
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      mosi_m_r <= 1'b0;
      mosi_s_r <= 1'b0;
      strap_m_r <= 1'b0;
      strap_s_r <= 1'b0;
    end else begin
      ss_m_r <= spi_ss_n;
      ss_s_r <= ss_m_r;
      ss_d_r <= ss_s_r;
      sck_m_r <= spi_sck;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      mosi_m_r <= spi_mosi;
      mosi_s_r <= mosi_m_r;
      strap_m_r <= spread_strap;
      strap_s_r <= strap_m_r;
    end
  end

  wire ss_low = ~ss_s_r;
  wire ss_fall = ss_d_r & ~ss_s_r;
  wire sck_rise = sck_s_r & ~sck_d_r;
  wire sck_fall = ~sck_s_r & sck_d_r;

  // ****************************
  // start-up sequencing
  // ****************************
  reg [27:0] boot_cnt_r;
  reg init_done_r, spi_rdy_r, full_r;

  // one saturating timer marks each start-up milestone
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r <= 28'h0000000;
      init_done_r <= 1'b0;
      spi_rdy_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      if (boot_cnt_r != FULL_CYC)
        boot_cnt_r <= boot_cnt_r + 28'h0000001;
      init_done_r <= init_done_r | (boot_cnt_r >= INIT_CYC); // RQ3
      spi_rdy_r <= spi_rdy_r | (boot_cnt_r >= SPI_RDY_CYC); // RQ4
      full_r <= full_r | (boot_cnt_r >= FULL_CYC); // RQ7
    end
  end

  wire init_rise = (boot_cnt_r == INIT_CYC) & ~init_done_r;

  // ****************************
  // register port state
  // ****************************
  reg lp_r, supp_r, recal_r, apply_r;
  reg [23:0] tx_r;
  reg [7:0] key_ok_r;
  reg tx_chg_r;
  reg cal_done_r;
  reg [23:0] rx_cfg_r;

  // software-facing controls; reset gives continuous mode, no suppression
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_r <= 1'b0; // RQ9
      supp_r <= 1'b0; // RQ9
      recal_r <= 1'b0;
      apply_r <= 1'b0;
      tx_r <= 24'h000000;
      key_ok_r <= 8'hFF;
      tx_chg_r <= 1'b0;
    end else begin
      recal_r <= 1'b0;
      apply_r <= 1'b0;
      tx_chg_r <= 1'b0;
      if (reg_wr && reg_addr == `TSHI_A_CTRL) begin
        lp_r <= reg_wdata[`TSHI_C_LP];
        supp_r <= reg_wdata[`TSHI_C_SUPP];
        recal_r <= reg_wdata[`TSHI_C_RECAL];
        apply_r <= reg_wdata[`TSHI_C_APPLY];
      end
      if (reg_wr && reg_addr == `TSHI_A_TX) begin
        tx_r <= reg_wdata[23:0];
        tx_chg_r <= (reg_wdata[23:0] != tx_r); // RQ17
      end
      if (reg_wr && reg_addr == `TSHI_A_KEYOK)
        key_ok_r <= reg_wdata[7:0]; // RQ8
    end
  end

  // key state sent out; masked keys and pre-calibration touches hidden
  wire [23:0] tx_frame = cal_done_r ? {tx_r[23:8], tx_r[7:0] & key_ok_r} : 24'h000000; // RQ6 RQ8 RQ12

  // ****************************
  // serial slave
  // ****************************
  reg [4:0] bit_cnt_r;
  reg [23:0] shin_r, shout_r;
  reg [27:0] tmo_r;
  reg xfer_done_r, abort_r;

  wire in_frame = (bit_cnt_r != 5'h00) | ss_low;

  // frame survives select rising between bytes; only timeout restarts it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 5'h00;
      shin_r <= 24'h000000;
      shout_r <= 24'h000000;
      tmo_r <= 28'h0000000;
      xfer_done_r <= 1'b0;
      abort_r <= 1'b0;
      rx_cfg_r <= 24'h000000;
      spi_miso_o <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      xfer_done_r <= 1'b0;
      abort_r <= 1'b0;
      spi_miso_oe <= spi_rdy_r & ss_low; // RQ25 RQ10
      if (!spi_rdy_r) begin
        bit_cnt_r <= 5'h00; // RQ4
        tmo_r <= 28'h0000000;
      end else if (tmo_r >= TMO_CYC) begin
        bit_cnt_r <= 5'h00; // RQ11
        tmo_r <= 28'h0000000;
        abort_r <= 1'b1;
      end else begin
        tmo_r <= in_frame ? tmo_r + 28'h0000001 : 28'h0000000;
        // first bit must be on the line before the first rising edge
        if (ss_fall && bit_cnt_r == 5'h00) begin
          spi_miso_o <= tx_frame[23];
          shout_r <= {tx_frame[22:0], 1'b0};
        end
        if (ss_low && sck_rise) begin
          shin_r <= {shin_r[22:0], mosi_s_r}; // RQ14
          if (bit_cnt_r == `TSHI_LAST_BIT) begin
            bit_cnt_r <= 5'h00; // RQ23
            rx_cfg_r <= {shin_r[22:0], mosi_s_r}; // RQ12
            xfer_done_r <= 1'b1;
            tmo_r <= 28'h0000000;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'h01; // RQ15
          end
        end
        // no shift after the last bit: next frame reloads on select
        if (ss_low && sck_fall && bit_cnt_r != 5'h00) begin
          spi_miso_o <= shout_r[23]; // RQ14
          shout_r <= {shout_r[22:0], 1'b0};
        end
      end
    end
  end

  // ****************************
  // change flag
  // ****************************
  wire change_set = init_rise | tx_chg_r | apply_r; // RQ5 RQ17 RQ18

  // set beats clear so an event in the reading cycle is kept
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change_flag_o <= 1'b0;
      change_flag_oe <= 1'b0; // RQ2
    end else begin
      change_flag_oe <= init_done_r | init_rise; // RQ3
      if (change_set)
        change_flag_o <= 1'b1; // RQ3
      else if (xfer_done_r)
        change_flag_o <= 1'b0; // RQ19
    end
  end

  // ****************************
  // burst timing and idle flag
  // ****************************
  reg [1:0] state_r;
  reg [27:0] tmr_r;
  reg xlow_r;
  reg [3:0] burst_cnt_r;
  wire [27:0] gap_len = lp_r ? LP_GAP_CYC : GAP_CYC;

  // bursts are timed only; the idle flag tracks them for the host
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      tmr_r <= 28'h0000000;
      xlow_r <= 1'b0;
      burst_cnt_r <= 4'h0;
      cal_done_r <= 1'b0;
      acquisition_idle_flag_o <= 1'b0;
      acquisition_idle_flag_oe <= 1'b0; // RQ2
    end else begin
      acquisition_idle_flag_oe <= init_done_r | init_rise; // RQ3
      tmr_r <= tmr_r + 28'h0000001;
      if (xfer_done_r)
        xlow_r <= 1'b1; // RQ21
      if (recal_r) begin
        burst_cnt_r <= 4'h0; // RQ8
        cal_done_r <= 1'b0;
      end
      case (state_r)
        ST_OFF: begin
          acquisition_idle_flag_o <= 1'b0; // RQ3
          tmr_r <= 28'h0000000;
          if (init_done_r)
            state_r <= ST_BURST;
        end
        ST_BURST: begin
          if (ss_fall && spi_rdy_r && tmr_r < GRACE_CYC) begin
            state_r <= ST_HOLD; // RQ22
            acquisition_idle_flag_o <= 1'b1;
          end else if (tmr_r >= BURST_CYC - 28'h0000001) begin
            state_r <= ST_GAP;
            tmr_r <= 28'h0000000;
            // a frame ending on this very edge keeps the flag low one more burst
            xlow_r <= xfer_done_r; // RQ21
            acquisition_idle_flag_o <= ~xfer_done_r; // RQ20
            if (!recal_r && burst_cnt_r != `TSHI_CAL_BURSTS)
              burst_cnt_r <= burst_cnt_r + 4'h1;
            if (!recal_r && burst_cnt_r == `TSHI_CAL_BURSTS - 4'h1)
              cal_done_r <= 1'b1; // RQ6
          end else begin
            acquisition_idle_flag_o <= 1'b0; // RQ20
          end
        end
        ST_GAP: begin
          acquisition_idle_flag_o <= ~(xlow_r | xfer_done_r); // RQ20 RQ21
          if (tmr_r >= gap_len) begin
            state_r <= ST_BURST;
            tmr_r <= 28'h0000000;
            acquisition_idle_flag_o <= 1'b0;
          end
        end
        ST_HOLD: begin
          tmr_r <= 28'h0000000;
          acquisition_idle_flag_o <= 1'b1; // RQ22
          if (xfer_done_r || abort_r) begin
            state_r <= ST_BURST;
            acquisition_idle_flag_o <= 1'b0; // RQ21
          end
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end
  end

  // ****************************
  // strap, sleep permission, readback
  // ****************************
  // strap is caught once, after reset, from its synchronised copy
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spread_en_o <= 1'b0;
      sleep_ok_o <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      if (init_rise)
        spread_en_o <= strap_s_r; // RQ1
      sleep_ok_o <= (state_r == ST_GAP) & lp_r & ~ss_low & ~in_frame; // RQ16
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `TSHI_A_CTRL: reg_rdata <= {30'h00000000, supp_r, lp_r};
          `TSHI_A_TX: reg_rdata <= {8'h00, tx_r};
          `TSHI_A_KEYOK: reg_rdata <= {24'h000000, key_ok_r};
          `TSHI_A_RXCFG: reg_rdata <= {8'h00, rx_cfg_r};
          `TSHI_A_STAT: reg_rdata <= {20'h00000, burst_cnt_r, full_r, cal_done_r,
            spi_rdy_r, spread_en_o, ss_low, change_flag_o, acquisition_idle_flag_o,
            xlow_r};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // tshi_top
`default_nettype wire

//--- bench/tshi_checker.sv
/*
  Port checker for tshi_top: start-up levels, spi pin hygiene, flag links.
  Bound from the bench top; sees one clock domain only.
*/
`timescale 1ns/1ps
`default_nettype none
module tshi_checker #(
  parameter [27:0] SPI_RDY_CYC = 28'h1F4
) (
  input wire clk,
  input wire rst_n,
  input wire spread_strap,
  input wire spi_ss_n,
  input wire spi_sck,
  input wire spi_miso_o,
  input wire spi_miso_oe,
  input wire change_flag_o,
  input wire change_flag_oe,
  input wire acquisition_idle_flag_o,
  input wire acquisition_idle_flag_oe,
  input wire spread_en_o,
  input wire sleep_ok_o
);
  reg [27:0] up_r;
  wire [27:0] up_nxt = (up_r == SPI_RDY_CYC) ? up_r : up_r + 28'h1;
  // edges since release; saturates so it never wraps in long runs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      up_r <= 28'h0;
    else
      up_r <= up_nxt;
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // *******************************
  // properties
  // *******************************
  property p_rst_quiet;
    disable iff (1'b0)
    !rst_n |-> !spi_miso_oe && !change_flag_oe && !acquisition_idle_flag_oe;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pin driven in reset");
  property p_init_lvl;
    $rose(change_flag_oe) |->
      change_flag_o && acquisition_idle_flag_oe && !acquisition_idle_flag_o;
  endproperty
  a_init_lvl: assert property (p_init_lvl) else $error("bad start levels");
  property p_init_hold;
    $rose(change_flag_oe) |=> change_flag_o [*8];
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("change dropped");
  property p_sprd;
    $rose(change_flag_oe) |-> spread_en_o == spread_strap;
  endproperty
  a_sprd: assert property (p_sprd) else $error("spread not strap");
  property p_spi_off;
    (up_r < SPI_RDY_CYC - 28'h8) |-> !spi_miso_oe;
  endproperty
  a_spi_off: assert property (p_spi_off) else $error("spi early");
  property p_miso_idle;
    spi_ss_n [*5] |-> !spi_miso_oe;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven");
  property p_miso_edge;
    spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso_o) |-> !$past(spi_sck, 2);
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved on rise");
  property p_sleep;
    !spi_ss_n [*6] |-> !sleep_ok_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep with select low");
  property p_clr;
    $fell(change_flag_o) |-> !acquisition_idle_flag_o;
  endproperty
  a_clr: assert property (p_clr) else $error("change cleared without frame");
endmodule // tshi_checker
`default_nettype wire

//--- bench/tshi_host_model.sv
/*
  Host spi master model: select, clock, data out; msb first, mode 0 style.
  Assumes continuous acquisition, so a 2.1 us select-to-clock wait.
*/
`timescale 1ns/1ps
`default_nettype none
module tshi_host_model (
  output logic ss_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  logic [23:0] rx;
  // idle: select high, clock parked low between frames
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    rx = 24'h0;
  end
  // one frame; fewer than 24 bits leaves the device to time out
  task automatic frame(input logic [23:0] v, input int nbits, input logic split);
    // leave the core clock's edge grid so no pin moves on a sampling edge
    #1.25;
    for (int i = 0; i < nbits; i++) begin
      if (i % 8 == 0 && (split || i == 0)) begin
        // let the device shift its next bit before select goes up
        #100;
        ss_n = 1'b1;
        #300;
        ss_n = 1'b0;
        #2100;
      end
      mosi = v[23 - i];
      #24 sck = 1'b1;
      rx = {rx[22:0], miso};
      #24 sck = 1'b0;
    end
    #100;
    ss_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule // tshi_host_model
`default_nettype wire

//--- bench/tb_tshi_top.sv
/*
  Self-checking bench for tshi_top with the host model on the spi pins.
  Assumes shortened count parameters and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_tshi_top;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic strap = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic miso_q = 1'b0;
  logic [31:0] d;
  int miscompares = 0;
  int n_checks = 0;
  wire [31:0] rdata;
  wire ss_n, sck, mosi, miso_o, miso_oe, chg, chg_oe, idl, idl_oe, sprd, slp;
  // released miso shows the inverse of its last value, never a held bit
  wire miso_w = miso_oe ? miso_o : ~miso_q;
  // rows: tx word, key mask, host bytes, expected returned frame
  logic [79:0] rows [3] = '{80'hA5C3F0_FF_123456_A5C3F0,
    80'h5A3C0F_3C_FEDCBA_5A3C0C, 80'h800181_00_000001_800100};
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (miso_oe)
      miso_q <= miso_o;
  end
  // the low-power gap keeps its full length; the sleep case only needs it long
  tshi_top #(.SPI_RDY_CYC(28'h1F4), .FULL_CYC(28'h7D0), .TMO_CYC(28'h1388),
    .GAP_CYC(28'hC8), .BURST_CYC(28'h12C)) u_tshi_top (
    .clk(clk), .rst_n(rst_n), .spread_strap(strap), .spi_ss_n(ss_n), .spi_sck(sck),
    .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe), .change_flag_o(chg),
    .change_flag_oe(chg_oe), .acquisition_idle_flag_o(idl),
    .acquisition_idle_flag_oe(idl_oe), .spread_en_o(sprd), .sleep_ok_o(slp),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  tshi_host_model u_tshi_host_model (.ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso_w));
  // *******************************
  // tasks
  // *******************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_st(input int b);
    for (int i = 0; i < 9000; i++) begin
      rreg(8'h10);
      if (d[b] === 1'b1)
        return;
    end
    miscompares++;
    tally_and_finish();
  endtask
  // bounded wait for the idle flag (w 0) or sleep permission (w 1) to reach v
  task automatic wait_lvl(input int w, input logic v);
    for (int i = 0; i < 2000; i++) begin
      cyc(1);
      #1;
      if ((w == 0 ? idl : slp) === v)
        return;
    end
    miscompares++;
    tally_and_finish();
  endtask
  // *******************************
  // sequence
  // *******************************
  initial begin
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(210);
    chb(sprd, 1'b1);
    // select falls before the port is ready; the checker sees miso stay off until the port is ready
    u_tshi_host_model.frame(24'h800000, 1, 1'b0);
    wait_st(6);
    foreach (rows[i]) begin
      wreg(8'h08, {24'h0, rows[i][55:48]});
      wreg(8'h04, {8'h0, rows[i][79:56]});
      cyc(4);
      chb(chg, 1'b1);
      wait_lvl(0, 1'b1);
      chb(idl, 1'b1);
      u_tshi_host_model.frame(rows[i][47:24], 24, 1'b0);
      cyc(10);
      chk({8'h0, u_tshi_host_model.rx}, {8'h0, rows[i][23:0]});
      rreg(8'h0C);
      chk(d, {8'h0, rows[i][47:24]});
      chb(chg, 1'b0);
    end
    // part frame starts just inside a burst: grace holds the flag high,
    // then the timeout drops the frame so the next whole frame lines up
    wait_lvl(0, 1'b1);
    wait_lvl(0, 1'b0);
    u_tshi_host_model.frame(24'hFFFFFF, 8, 1'b0);
    chb(idl, 1'b1);
    cyc(5100);
    u_tshi_host_model.frame(24'h0F0F0F, 24, 1'b0);
    rreg(8'h0C);
    chk(d, 32'h0F0F0F);
    chk({8'h0, u_tshi_host_model.rx}, 32'h800100);
    u_tshi_host_model.frame(24'h3C5A96, 24, 1'b1);
    rreg(8'h0C);
    chk(d, 32'h3C5A96);
    chk({8'h0, u_tshi_host_model.rx}, 32'h800100);
    wreg(8'h00, 32'h8);
    cyc(4);
    chb(chg, 1'b1);
    wreg(8'h00, 32'h1);
    rreg(8'h00);
    chk(d, 32'h1);
    wait_lvl(1, 1'b1);
    chb(slp, 1'b1);
    // a frame with select low must withdraw the sleep permission
    u_tshi_host_model.frame(24'h00000F, 24, 1'b0);
    chk({8'h0, u_tshi_host_model.rx}, 32'h800100);
    wreg(8'h00, 32'h4);
    cyc(4);
    rreg(8'h10);
    chb(d[6], 1'b0);
    rreg(8'h20);
    chk(d, 32'h0);
    // second reset with the strap low, checked from the first edges on
    cyc(1);
    rst_n <= 1'b0;
    strap <= 1'b0;
    cyc(1);
    chk({29'h0, miso_oe, chg_oe, idl_oe}, 32'h0);
    cyc(3);
    rst_n <= 1'b1;
    cyc(210);
    chk({28'h0, chg, chg_oe, idl, idl_oe}, 32'hD);
    chb(sprd, 1'b0);
    rreg(8'h00);
    chk(d, 32'h0);
    rreg(8'h08);
    chk(d, 32'hFF);
    rreg(8'h10);
    chb(d[5], 1'b0);
    wait_st(5);
    chb(chg, 1'b1);
    wreg(8'h04, 32'hFFFFFF);
    u_tshi_host_model.frame(24'h000001, 24, 1'b0);
    cyc(10);
    chk({8'h0, u_tshi_host_model.rx}, 32'h0);
    chb(chg, 1'b0);
    tally_and_finish();
  end
endmodule // tb_tshi_top
bind tshi_top tshi_checker #(.SPI_RDY_CYC(SPI_RDY_CYC)) u_tshi_checker (
  .clk(clk), .rst_n(rst_n), .spread_strap(spread_strap), .spi_ss_n(spi_ss_n),
  .spi_sck(spi_sck), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
  .change_flag_o(change_flag_o), .change_flag_oe(change_flag_oe),
  .acquisition_idle_flag_o(acquisition_idle_flag_o),
  .acquisition_idle_flag_oe(acquisition_idle_flag_oe),
  .spread_en_o(spread_en_o), .sleep_ok_o(sleep_ok_o));
`default_nettype wire
